// File: inc/dtap_pkg.sv
// Shared constants for the dual auto-reload timer and wave block
package dtap_pkg;
  // Register byte addresses
  localparam logic [3:0] OFF_CONTROL     = 4'h0;
  localparam logic [3:0] OFF_MODE        = 4'h1;
  localparam logic [3:0] OFF_CONTROL_B   = 4'h2;
  localparam logic [3:0] OFF_CLOCK       = 4'h3;
  localparam logic [3:0] OFF_U0_LOW_CNT  = 4'h4;
  localparam logic [3:0] OFF_U1_LOW_CNT  = 4'h5;
  localparam logic [3:0] OFF_U0_HIGH_CNT = 4'h6;
  localparam logic [3:0] OFF_U1_HIGH_CNT = 4'h7;
  localparam logic [3:0] OFF_U0_LOW_RLD  = 4'h8;
  localparam logic [3:0] OFF_U1_LOW_RLD  = 4'h9;
  localparam logic [3:0] OFF_U0_HIGH_RLD = 4'ha;
  localparam logic [3:0] OFF_U1_HIGH_RLD = 4'hb;

  // Control register fields
  localparam int BIT_RUN0  = 4;
  localparam int BIT_FLAG0 = 5;
  localparam int BIT_RUN1  = 6;
  localparam int BIT_FLAG1 = 7;
  // Mode register fields, unit n at base 4*n
  localparam int POS_MODE  = 0;
  localparam int BIT_CT    = 2;
  localparam int BIT_GATE  = 3;
  localparam int UNIT_STEP = 4;
  // Control B fields
  localparam int POS_PSC0  = 0;
  localparam int POS_PSC1  = 3;
  localparam int BIT_WAVE0 = 6;
  localparam int BIT_WAVE1 = 7;
  // Clock control fields
  localparam int BIT_DBL0  = 0;
  localparam int BIT_DBL1  = 1;
  localparam int BIT_FAST  = 2;
  localparam int POS_TPS   = 4;

  // Reset values
  localparam logic [7:0] RST_CONTROL   = 8'h00;
  localparam logic [7:0] RST_MODE      = 8'h00;
  localparam logic [7:0] RST_CONTROL_B = 8'h24;
  localparam logic [7:0] RST_CLOCK     = 8'h04;
  localparam logic [7:0] RST_BYTE      = 8'h00;

  // Mode encodings
  localparam logic [1:0] MODE_VAR   = 2'b00;
  localparam logic [1:0] MODE_AR16  = 2'b01;
  localparam logic [1:0] MODE_AR8   = 2'b10;
  localparam logic [1:0] MODE_SPLIT = 2'b11;
endpackage : dtap_pkg

// File: logic/dtap_prescale.sv
// Shared timer prescaler and per-unit count step enables
`timescale 1ns/100ps
module dtap_prescale (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [3:0] i_value,
  input  wire logic       i_fast,
  input  wire logic [1:0] i_dbl,
  output logic      [1:0] o_step
);
  import dtap_pkg::*;

  logic [3:0] cnt_reg;
  logic       tick;
  logic [1:0] phase_reg;

  assign tick = (cnt_reg == i_value);

  always_ff @(posedge i_clk) begin
    if (i_rst || tick) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  genvar n;
  generate
    for (n = 0; n < 2; n++) begin : g_unit
      // Compatibility mode with the double-rate bit set halves the rate
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          phase_reg[n] <= 1'b0;
        end else if (tick) begin
          phase_reg[n] <= ~phase_reg[n];
        end
      end
      always_comb begin
        if (i_fast && !i_dbl[n]) begin
          o_step[n] = 1'b1;
        end else if (!i_fast && i_dbl[n]) begin
          o_step[n] = tick & phase_reg[n];
        end else begin
          o_step[n] = tick;
        end
      end
    end
  endgenerate
endmodule : dtap_prescale

// File: logic/dtap_wave.sv
// One wave output channel: buffered compare, PWM and toggle modes
`timescale 1ns/100ps
module dtap_wave (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_adv,
  input  wire logic       i_wrap,
  input  wire logic [7:0] i_next,
  input  wire logic [7:0] i_duty,
  input  wire logic       i_toggle_mode,
  output logic            o_level
);
  import dtap_pkg::*;

  logic [7:0] buffered_compare_reg;

  // Duty only lands at the wrap, so a mid-period write cannot glitch
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      buffered_compare_reg <= RST_BYTE;
    end else if (i_wrap && !i_toggle_mode) begin
      buffered_compare_reg <= i_duty;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_level <= 1'b0;
    end else if (i_toggle_mode) begin
      if (i_wrap) begin
        o_level <= ~o_level;
      end
    end else if (i_wrap) begin
      o_level <= (i_duty != 8'h00);
    end else if (i_adv && i_next == buffered_compare_reg) begin
      o_level <= 1'b0;
    end
  end
endmodule : dtap_wave

// File: logic/dtap_timer.sv
// Two auto-reload timer/counter units with wave outputs and registers
// Operation
// - Mode 1 16-bit count, reload, flag on wrap
// - Reload pair resets to zero
// - Mode 1 period is 65536 minus reload
// - Prescaler applies per fast mode and double-rate bit
// - Mode 2 low byte reloads from high byte
// - Mode 2 period is 256 minus high byte
// - Unit 1 reload pair is storage in mode 2
// - Unit 1 mode 3 freezes its count
// - Unit 0 mode 3 high byte uses unit 1
// - Unit 1 flag follows the split high half during unit 0 split
// - Split halves overflow every 256 steps
// - Flags and gate keep working under PWM
// - Output high on wrap, low on compare
// - Duty copied to compare only at wrap
// - Zero duty keeps output low
// - PWM mode 0 uses logarithmic low-byte prescaler
// - PWM mode 1 low byte reloads linearly
// - High time is duty out of 256
// - PWM mode 2 toggles output on overflow
// - PWM mode 3 gives two split channels
// - PWM mode 3 frequency set by prescaler only
// - Count when run and gate open
// - Two mode bits select the mode
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module dtap_timer (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_unit0_gate_pin,
  input  wire logic       i_unit1_gate_pin,
  input  wire logic       i_unit0_pin,
  input  wire logic       i_unit1_pin,
  output logic            o_unit0_pin,
  output logic            o_unit0_pin_oe,
  output logic            o_unit1_pin,
  output logic            o_unit1_pin_oe,
  output logic            o_unit0_overflow_flag,
  output logic            o_unit1_overflow_flag,
  output logic            o_unit1_baud_pulse
);
  import dtap_pkg::*;

  logic [7:0] timer_control_reg;
  logic [7:0] timer_mode_reg;
  logic [7:0] timer_control_b_reg;
  logic [7:0] clock_control_reg;
  logic [7:0] low_count_reg   [2];
  logic [7:0] high_count_reg  [2];
  logic [7:0] low_reload_reg  [2];
  logic [7:0] high_reload_reg [2];
  logic [7:0] low_count_next  [2];
  logic [7:0] high_count_next [2];
  logic [7:0] rdata_reg;

  logic [1:0] step;
  logic [1:0] pin_prev_reg;
  logic [1:0] pin_fall;
  logic [1:0] mode [2];
  logic [1:0] gate_pin;
  logic [1:0] run;
  logic [1:0] wave_en;
  logic [1:0] ovf;
  logic [1:0] high_adv;
  logic [1:0] low_adv;
  logic       split0;
  logic       split_high_adv;
  logic       split_high_ovf;
  logic       low_ovf0;
  logic [1:0] set_flag;
  logic [1:0] wave_adv;
  logic [1:0] wave_wrap;
  logic [7:0] wave_next [2];
  logic [7:0] wave_duty [2];
  logic [1:0] wave_toggle;

  assign run      = {timer_control_reg[BIT_RUN1], timer_control_reg[BIT_RUN0]};
  assign wave_en  = {timer_control_b_reg[BIT_WAVE1],
                     timer_control_b_reg[BIT_WAVE0]};
  assign gate_pin = {i_unit1_gate_pin, i_unit0_gate_pin};
  assign split0   = (mode[0] == MODE_SPLIT);

  dtap_prescale u_prescale (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_value (clock_control_reg[POS_TPS +: 4]),
    .i_fast  (clock_control_reg[BIT_FAST]),
    .i_dbl   ({clock_control_reg[BIT_DBL1], clock_control_reg[BIT_DBL0]}),
    .o_step  (step)
  );

  // Counter inputs are taken on a falling edge of the unit pin
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_prev_reg <= 2'b00;
    end else begin
      pin_prev_reg <= {i_unit1_pin, i_unit0_pin};
    end
  end
  assign pin_fall = pin_prev_reg & ~{i_unit1_pin, i_unit0_pin};

  genvar n;
  generate
    for (n = 0; n < 2; n++) begin : g_unit
      logic       gate;
      logic       ct;
      logic       enable;
      logic       adv;
      logic [7:0] low_mask;
      logic [2:0] psc;

      assign mode[n] = timer_mode_reg[UNIT_STEP*n + POS_MODE +: 2];
      assign gate    = timer_mode_reg[UNIT_STEP*n + BIT_GATE];
      assign ct      = timer_mode_reg[UNIT_STEP*n + BIT_CT];
      assign psc     = timer_control_b_reg[(n == 0 ? POS_PSC0 : POS_PSC1) +: 3];
      assign enable  = run[n] & (~gate | gate_pin[n]);
      // Unit 1 in split mode holds, just as with its run bit clear
      assign adv     = enable & (ct ? pin_fall[n] : step[n])
                       & ~(n == 1 && mode[n] == MODE_SPLIT);
      assign low_mask = 8'((9'h002 << psc) - 9'h001);

      always_comb begin
        low_count_next[n]  = low_count_reg[n];
        high_count_next[n] = high_count_reg[n];
        low_adv[n]  = 1'b0;
        high_adv[n] = 1'b0;
        ovf[n]      = 1'b0;
        unique case (mode[n])
          MODE_VAR: begin
            // Low byte is a logarithmic prescaler of psc+1 bits
            if (adv) begin
              low_adv[n] = 1'b1;
              if ((low_count_reg[n] & low_mask) == low_mask) begin
                low_count_next[n]  = 8'h00;
                high_count_next[n] = high_count_reg[n] + 8'h01;
                high_adv[n] = 1'b1;
                ovf[n]      = (high_count_reg[n] == 8'hff);
              end else begin
                low_count_next[n] = low_count_reg[n] + 8'h01;
              end
            end
          end
          MODE_AR16: begin
            if (adv && wave_en[n]) begin
              low_adv[n] = 1'b1;
              if (low_count_reg[n] == 8'hff) begin
                low_count_next[n]  = low_reload_reg[n];
                high_count_next[n] = high_count_reg[n] + 8'h01;
                high_adv[n] = 1'b1;
                ovf[n]      = (high_count_reg[n] == 8'hff);
              end else begin
                low_count_next[n] = low_count_reg[n] + 8'h01;
              end
            end else if (adv) begin
              low_adv[n] = 1'b1;
              high_adv[n] = 1'b1;
              if ({high_count_reg[n], low_count_reg[n]} == 16'hffff) begin
                low_count_next[n]  = low_reload_reg[n];
                high_count_next[n] = high_reload_reg[n];
                ovf[n] = 1'b1;
              end else begin
                {high_count_next[n], low_count_next[n]} =
                  {high_count_reg[n], low_count_reg[n]} + 16'h0001;
              end
            end
          end
          MODE_AR8: begin
            // Reload pair untouched here, so software may use it freely
            if (adv) begin
              low_adv[n] = 1'b1;
              if (low_count_reg[n] == 8'hff) begin
                low_count_next[n] = high_count_reg[n];
                ovf[n] = 1'b1;
              end else begin
                low_count_next[n] = low_count_reg[n] + 8'h01;
              end
            end
          end
          MODE_SPLIT: begin
            if (n == 0) begin
              if (adv) begin
                low_adv[n] = 1'b1;
                low_count_next[n] = low_count_reg[n] + 8'h01;
                ovf[n] = (low_count_reg[n] == 8'hff);
              end
              if (split_high_adv) begin
                high_adv[n] = 1'b1;
                high_count_next[n] = high_count_reg[n] + 8'h01;
              end
            end
          end
        endcase
      end
    end
  endgenerate

  // Split high half counts timer steps only, run by unit 1's run bit
  assign split_high_adv = split0 & run[1] & step[0];
  assign split_high_ovf = split_high_adv & (high_count_reg[0] == 8'hff);
  assign low_ovf0       = ovf[0];

  assign set_flag[0] = low_ovf0;
  assign set_flag[1] = split0 ? split_high_ovf : ovf[1];
  assign o_unit1_baud_pulse = ovf[1];

  // Wave channel 0 follows unit 0; channel 1 follows unit 1, or the split high half when unit 0 is in split mode
  always_comb begin
    wave_toggle = {mode[1] == MODE_AR8, mode[0] == MODE_AR8};
    if (split0) begin
      wave_adv[0]  = low_adv[0];
      wave_wrap[0] = low_ovf0;
      wave_next[0] = low_count_next[0];
      wave_duty[0] = low_reload_reg[0];
    end else if (mode[0] == MODE_AR8) begin
      wave_adv[0]  = low_adv[0];
      wave_wrap[0] = ovf[0];
      wave_next[0] = low_count_next[0];
      wave_duty[0] = high_reload_reg[0];
    end else begin
      wave_adv[0]  = high_adv[0];
      wave_wrap[0] = ovf[0];
      wave_next[0] = high_count_next[0];
      wave_duty[0] = high_reload_reg[0];
    end
    if (split0) begin
      wave_toggle[1] = 1'b0;
      wave_adv[1]  = split_high_adv;
      wave_wrap[1] = split_high_ovf;
      wave_next[1] = high_count_next[0];
      wave_duty[1] = high_reload_reg[0];
    end else if (mode[1] == MODE_AR8) begin
      wave_adv[1]  = low_adv[1];
      wave_wrap[1] = ovf[1];
      wave_next[1] = low_count_next[1];
      wave_duty[1] = high_reload_reg[1];
    end else begin
      wave_adv[1]  = high_adv[1];
      wave_wrap[1] = ovf[1];
      wave_next[1] = high_count_next[1];
      wave_duty[1] = high_reload_reg[1];
    end
  end

  dtap_wave u_wave0 (
    .i_clk         (i_clk),
    .i_rst         (i_rst),
    .i_adv         (wave_adv[0]),
    .i_wrap        (wave_wrap[0]),
    .i_next        (wave_next[0]),
    .i_duty        (wave_duty[0]),
    .i_toggle_mode (wave_toggle[0]),
    .o_level       (o_unit0_pin)
  );

  dtap_wave u_wave1 (
    .i_clk         (i_clk),
    .i_rst         (i_rst),
    .i_adv         (wave_adv[1]),
    .i_wrap        (wave_wrap[1]),
    .i_next        (wave_next[1]),
    .i_duty        (wave_duty[1]),
    .i_toggle_mode (wave_toggle[1]),
    .o_level       (o_unit1_pin)
  );

  // Pins drive only with the wave enable; timer selection is software's job
  assign o_unit0_pin_oe = wave_en[0];
  assign o_unit1_pin_oe = wave_en[1];

  // Control register: a hardware set beats a software clear in one cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      timer_control_reg <= RST_CONTROL;
    end else begin
      if (i_wr && i_addr == OFF_CONTROL) begin
        timer_control_reg <= i_wdata & 8'hf0;
      end
      if (set_flag[0]) begin
        timer_control_reg[BIT_FLAG0] <= 1'b1;
      end
      if (set_flag[1]) begin
        timer_control_reg[BIT_FLAG1] <= 1'b1;
      end
    end
  end
  assign o_unit0_overflow_flag = timer_control_reg[BIT_FLAG0];
  assign o_unit1_overflow_flag = timer_control_reg[BIT_FLAG1];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      timer_mode_reg      <= RST_MODE;
      timer_control_b_reg <= RST_CONTROL_B;
      clock_control_reg   <= RST_CLOCK;
    end else if (i_wr) begin
      if (i_addr == OFF_MODE) begin
        timer_mode_reg <= i_wdata;
      end
      if (i_addr == OFF_CONTROL_B) begin
        timer_control_b_reg <= i_wdata;
      end
      if (i_addr == OFF_CLOCK) begin
        clock_control_reg <= i_wdata & 8'hf7;
      end
    end
  end

  // Count bytes: a software write takes precedence over counting
  generate
    for (n = 0; n < 2; n++) begin : g_store
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          low_count_reg[n]  <= RST_BYTE;
          high_count_reg[n] <= RST_BYTE;
        end else begin
          low_count_reg[n]  <= low_count_next[n];
          high_count_reg[n] <= high_count_next[n];
          if (i_wr && i_addr == OFF_U0_LOW_CNT + 4'(n)) begin
            low_count_reg[n] <= i_wdata;
          end
          if (i_wr && i_addr == OFF_U0_HIGH_CNT + 4'(n)) begin
            high_count_reg[n] <= i_wdata;
          end
        end
      end
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          low_reload_reg[n]  <= RST_BYTE;
          high_reload_reg[n] <= RST_BYTE;
        end else if (i_wr) begin
          if (i_addr == OFF_U0_LOW_RLD + 4'(n)) begin
            low_reload_reg[n] <= i_wdata;
          end
          if (i_addr == OFF_U0_HIGH_RLD + 4'(n)) begin
            high_reload_reg[n] <= i_wdata;
          end
        end
      end
    end
  endgenerate

  // Read data stands for the one cycle after the strobe; else zero
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_rd) begin
      rdata_reg <= 8'h00;
    end else begin
      unique case (i_addr)
        OFF_CONTROL:     rdata_reg <= timer_control_reg;
        OFF_MODE:        rdata_reg <= timer_mode_reg;
        OFF_CONTROL_B:   rdata_reg <= timer_control_b_reg;
        OFF_CLOCK:       rdata_reg <= clock_control_reg;
        OFF_U0_LOW_CNT:  rdata_reg <= low_count_reg[0];
        OFF_U1_LOW_CNT:  rdata_reg <= low_count_reg[1];
        OFF_U0_HIGH_CNT: rdata_reg <= high_count_reg[0];
        OFF_U1_HIGH_CNT: rdata_reg <= high_count_reg[1];
        OFF_U0_LOW_RLD:  rdata_reg <= low_reload_reg[0];
        OFF_U1_LOW_RLD:  rdata_reg <= low_reload_reg[1];
        OFF_U0_HIGH_RLD: rdata_reg <= high_reload_reg[0];
        OFF_U1_HIGH_RLD: rdata_reg <= high_reload_reg[1];
        default:         rdata_reg <= 8'h00;
      endcase
    end
  end
  assign o_rdata = rdata_reg;
endmodule : dtap_timer

// File: tb/dtap_timer_props.sv
// Port-level assertions for the dual timer block
`timescale 1ns/100ps
module dtap_timer_props
  import dtap_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       o_unit0_pin,
  input wire logic       o_unit0_pin_oe,
  input wire logic       o_unit1_pin,
  input wire logic       o_unit1_pin_oe,
  input wire logic       o_unit0_overflow_flag,
  input wire logic       o_unit1_overflow_flag,
  input wire logic       o_unit1_baud_pulse
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic wr_ctl;
  logic wr_cb;
  assign wr_ctl = i_wr && i_addr == OFF_CONTROL;
  assign wr_cb  = i_wr && i_addr == OFF_CONTROL_B;

  a_oe_wave0: assert property (
    wr_cb |=> o_unit0_pin_oe == $past(i_wdata[BIT_WAVE0]))
    else $error("unit0 drive enable does not follow its enable bit");
  a_oe_wave1: assert property (
    wr_cb |=> o_unit1_pin_oe == $past(i_wdata[BIT_WAVE1]))
    else $error("unit1 drive enable does not follow its enable bit");
  a_flag0_sticky: assert property (
    o_unit0_overflow_flag && !wr_ctl |=> o_unit0_overflow_flag)
    else $error("unit0 flag dropped without software");
  a_flag1_sticky: assert property (
    o_unit1_overflow_flag && !wr_ctl |=> o_unit1_overflow_flag)
    else $error("unit1 flag dropped without software");
  a_flag_soft_set: assert property (
    wr_ctl && i_wdata[BIT_FLAG0] |=> o_unit0_overflow_flag)
    else $error("unit0 flag not set by software");
  a_store_low: assert property (
    i_wr && i_addr == OFF_U1_LOW_RLD ##1 i_rd && i_addr == OFF_U1_LOW_RLD
    |=> o_rdata == $past(i_wdata, 2))
    else $error("unit1 low reload lost its stored value");
  a_mode_back: assert property (
    i_wr && i_addr == OFF_MODE ##1 i_rd && i_addr == OFF_MODE
    |=> o_rdata == $past(i_wdata, 2))
    else $error("mode bits read back wrong");
  a_reset_quiet: assert property (
    $past(i_rst) |-> !o_unit0_pin && !o_unit1_pin && !o_unit0_pin_oe
    && !o_unit0_overflow_flag && !o_unit1_overflow_flag)
    else $error("outputs not quiet after reset");
endmodule : dtap_timer_props

bind dtap_timer dtap_timer_props u_props (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_unit0_pin(o_unit0_pin),
  .o_unit0_pin_oe(o_unit0_pin_oe), .o_unit1_pin(o_unit1_pin),
  .o_unit1_pin_oe(o_unit1_pin_oe),
  .o_unit0_overflow_flag(o_unit0_overflow_flag),
  .o_unit1_overflow_flag(o_unit1_overflow_flag),
  .o_unit1_baud_pulse(o_unit1_baud_pulse));

// File: tb/dtap_pins.sv
// Far-side model: gate sources and pulled-up timer pins
`timescale 1ns/100ps
module dtap_pins (
  input  wire logic i_out0,
  input  wire logic i_oe0,
  input  wire logic i_out1,
  input  wire logic i_oe1,
  input  wire logic i_unit0_gate_select_req,
  input  wire logic i_gate1_req,
  output logic      o_wire0,
  output logic      o_wire1,
  output logic      o_unit0_gate_select,
  output logic      o_gate1
);
  // Released pins float to the pull-up level
  assign o_wire0 = i_oe0 ? i_out0 : 1'b1;
  assign o_wire1 = i_oe1 ? i_out1 : 1'b1;
  assign o_unit0_gate_select = i_unit0_gate_select_req;
  assign o_gate1 = i_gate1_req;
endmodule : dtap_pins

// File: tb/dtap_timer_tb.sv
// Self-checking bench for the dual timer block
`timescale 1ns/100ps
module dtap_timer_tb;
  import dtap_pkg::*;
  logic       i_clk, i_rst, i_wr, i_rd, gp0, gp1;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata;
  logic       g0, g1, w0, w1, out0, oe0, out1, oe1, f0, f1, baud;
  int         fails, tests_run;

  dtap_timer dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_unit0_gate_pin(g0), .i_unit1_gate_pin(g1), .i_unit0_pin(w0),
    .i_unit1_pin(w1), .o_unit0_pin(out0), .o_unit0_pin_oe(oe0),
    .o_unit1_pin(out1), .o_unit1_pin_oe(oe1),
    .o_unit0_overflow_flag(f0), .o_unit1_overflow_flag(f1),
    .o_unit1_baud_pulse(baud));
  dtap_pins u_pins (.i_out0(out0), .i_oe0(oe0), .i_out1(out1),
    .i_oe1(oe1), .i_unit0_gate_select_req(gp0), .i_gate1_req(gp1), .o_wire0(w0),
    .o_wire1(w1), .o_unit0_gate_select(g0), .o_gate1(g1));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t value %h, expected %h", $time, g, e);
    end
  endtask : chk8
  task automatic chkn(input int g, input int e);
    tests_run++;
    if (g != e) begin
      fails++;
      $display("[ERR] %0t count %0d, expected %0d", $time, g, e);
    end
  endtask : chkn
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    @(negedge i_clk);
    chk8(o_rdata, e);
  endtask : rd_chk
  // Write then read the same place with no gap between strobes
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
    i_rd    <= 1'b1;
    @(posedge i_clk);
    i_rd    <= 1'b0;
    @(negedge i_clk);
    chk8(o_rdata, d);
  endtask : wr_rd
  function automatic logic pick(input int s);
    return (s == 0) ? baud : (s == 1) ? out0 : out1;
  endfunction : pick
  // Rise-to-rise distance; the third rise is used so a phase change settles
  task automatic gap(input int s, output int n);
    int   k = 0;
    logic p = 1'b1;
    logic v;
    n = 0;
    while (k < 3 && n < 3000) begin
      @(negedge i_clk);
      n++;
      v = pick(s);
      if (v === 1'b1 && p !== 1'b1) begin
        k++;
        if (k < 3) n = 0;
      end
      p = v;
    end
  endtask : gap
  task automatic hi(input int s, output int n);
    int t = 0;
    n = 0;
    while (pick(s) !== 1'b0 && t < 3000) begin
      @(negedge i_clk);
      t++;
    end
    while (pick(s) !== 1'b1 && t < 3000) begin
      @(negedge i_clk);
      t++;
    end
    while (pick(s) === 1'b1 && t < 3000) begin
      @(negedge i_clk);
      n++;
      t++;
    end
  endtask : hi
  task automatic pulses(input int c, output int k);
    k = 0;
    repeat (c) begin
      @(negedge i_clk);
      if (baud === 1'b1) k++;
    end
  endtask : pulses

  task automatic t_reset;
    rd_chk(OFF_CONTROL_B, 8'h24);
    rd_chk(OFF_CLOCK, 8'h04);
    rd_chk(OFF_U1_LOW_RLD, 8'h00);
    rd_chk(OFF_U1_HIGH_RLD, 8'h00);
    rd_chk(4'hc, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_mode1;
    int n;
    wr_rd(OFF_MODE, 8'h10);
    wr(OFF_U1_HIGH_RLD, 8'hff);
    wr(OFF_U1_LOW_RLD, 8'hf0);
    // Start near the top so the first wrap is not 65536 steps away
    wr(OFF_U1_HIGH_CNT, 8'hff);
    wr(OFF_CONTROL, 8'h40);
    gap(0, n);
    chkn(n, 16);
    chk8({7'h00, f1}, 8'h01);
    wr(OFF_CLOCK, 8'h36);
    gap(0, n);
    chkn(n, 64);
    wr(OFF_CLOCK, 8'h32);
    gap(0, n);
    chkn(n, 128);
    wr(OFF_CLOCK, 8'h30);
    gap(0, n);
    chkn(n, 64);
    wr(OFF_CLOCK, 8'h04);
    $display("t_mode1 done");
  endtask : t_mode1
  task automatic t_mode2;
    int n;
    wr(OFF_MODE, 8'h20);
    wr(OFF_U1_HIGH_CNT, 8'hf0);
    gap(0, n);
    chkn(n, 16);
    rd_chk(OFF_U1_HIGH_CNT, 8'hf0);
    wr_rd(OFF_U1_LOW_RLD, 8'h5a);
    $display("t_mode2 done");
  endtask : t_mode2
  task automatic t_gate;
    int n;
    @(posedge i_clk);
    gp1 <= 1'b0;
    wr(OFF_MODE, 8'ha0);
    pulses(100, n);
    chkn(n, 0);
    @(posedge i_clk);
    gp1 <= 1'b1;
    gap(0, n);
    chkn(n, 16);
    wr(OFF_MODE, 8'h30);
    pulses(100, n);
    chkn(n, 0);
    $display("t_gate done");
  endtask : t_gate
  task automatic t_split;
    int n;
    wr(OFF_MODE, 8'h23);
    wr(OFF_CONTROL, 8'h50);
    gap(0, n);
    chkn(n, 16);
    // Split high half restarts at zero, so its wrap is 256 cycles away
    wr(OFF_U0_HIGH_CNT, 8'h00);
    wr(OFF_CONTROL, 8'h50);
    repeat (100) @(negedge i_clk);
    chk8({7'h00, f1}, 8'h00);
    repeat (200) @(negedge i_clk);
    chk8({7'h00, f1}, 8'h01);
    wr(OFF_CONTROL, 8'h70);
    $display("t_split done");
  endtask : t_split
  task automatic t_pwm2;
    int n;
    wr(OFF_CONTROL_B, 8'h64);
    wr(OFF_MODE, 8'h02);
    wr(OFF_U0_HIGH_CNT, 8'hf8);
    wr(OFF_CONTROL, 8'h10);
    gap(1, n);
    chkn(n, 16);
    chk8({7'h00, oe0}, 8'h01);
    $display("t_pwm2 done");
  endtask : t_pwm2
  task automatic t_pwm1;
    int n;
    wr(OFF_MODE, 8'h01);
    wr(OFF_U0_LOW_RLD, 8'hff);
    wr(OFF_U0_HIGH_RLD, 8'h40);
    hi(1, n);
    hi(1, n);
    chkn(n, 64);
    gap(1, n);
    chkn(n, 256);
    wr(OFF_U0_LOW_RLD, 8'hfe);
    gap(1, n);
    chkn(n, 512);
    wr(OFF_U0_HIGH_RLD, 8'h00);
    repeat (600) @(negedge i_clk);
    hi(1, n);
    chkn(n, 0);
    $display("t_pwm1 done");
  endtask : t_pwm1
  task automatic t_pwm3;
    int n;
    wr(OFF_CONTROL_B, 8'he4);
    wr(OFF_U0_LOW_RLD, 8'h20);
    wr(OFF_U0_HIGH_RLD, 8'h80);
    wr(OFF_MODE, 8'h03);
    wr(OFF_CONTROL, 8'h50);
    hi(1, n);
    chkn(n, 32);
    hi(2, n);
    chkn(n, 128);
    gap(2, n);
    chkn(n, 256);
    chk8({6'h00, oe1, f0}, 8'h03);
    wr(OFF_CONTROL_B, 8'h40);
    wr(OFF_MODE, 8'h00);
    gap(1, n);
    chkn(n, 512);
    $display("t_pwm3 done");
  endtask : t_pwm3

  task automatic close_out;
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  initial begin
    #1_000_000;
    fails++;
    $display("[ERR] %0t run did not finish", $time);
    close_out;
  end

  initial begin
    i_rst   = 1'b1;
    i_wr    = 1'b0;
    i_rd    = 1'b0;
    i_addr  = 4'h0;
    i_wdata = 8'h00;
    gp0     = 1'b1;
    gp1     = 1'b1;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset;
    t_mode1;
    t_mode2;
    t_gate;
    t_split;
    t_pwm2;
    t_pwm1;
    t_pwm3;
    close_out;
  end
endmodule : dtap_timer_tb
